// ---- door_drive_pkg.sv ----
// constants, state encoding and decode helpers for the door drive control
package door_drive_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ         = 40_000_000;
  localparam int FLASH_HALF_MS  = 500;
  localparam int FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
  localparam int PULSE_HALF_US  = 500;
  localparam int PULSE_HALF_CYC = CLK_HZ / 1_000_000 * PULSE_HALF_US;
  localparam int SKEW_S         = 2;
  localparam int SKEW_CYC       = CLK_HZ * SKEW_S;
  localparam int CLEAR_S        = 3;
  localparam int CLEAR_CYC      = CLK_HZ * CLEAR_S;
  localparam int TIMER_W        = 27;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] ADR_MODE       = 4'h0;
  localparam logic [ADDR_W-1:0] ADR_OPT_FUNC   = 4'h1;
  localparam logic [ADDR_W-1:0] ADR_OPEN_POS   = 4'h2;
  localparam logic [ADDR_W-1:0] ADR_PART_POS   = 4'h3;
  localparam logic [ADDR_W-1:0] ADR_FORCE      = 4'h4;
  localparam logic [ADDR_W-1:0] ADR_STATUS     = 4'h5;
  localparam logic [ADDR_W-1:0] ADR_CLOSED_POS = 4'h6;

  localparam int MODE_W = 3;
  localparam int OPT_W  = 2;
  localparam logic [MODE_W-1:0] MODE_RST = 3'h1;
  localparam logic [OPT_W-1:0]  OPT_RST  = 2'h1;
  localparam logic [OPT_W-1:0]  OPT_FUNC_REF  = 2'h1;
  localparam logic [DATA_W-1:0] OPEN_POS_RST  = 16'h4000;
  localparam logic [DATA_W-1:0] PART_POS_RST  = 16'h2000;
  localparam logic [DATA_W-1:0] FORCE_RST     = 16'h0100;
  localparam logic [1:0]        MATCH_NEED    = 2'h2;

  // status fields
  localparam int ST_REF_BIT    = 0;
  localparam int ST_NORMAL_BIT = 1;
  localparam int ST_TORQUE_BIT = 2;
  localparam int ST_WBREAK_BIT = 3;
  localparam int ST_STATE_LSB  = 4;

  typedef enum logic [2:0] {
    S_NOREF  = 3'b000,
    S_REFRUN = 3'b001,
    S_IDLE   = 3'b011,
    S_MOVE   = 3'b010,
    S_RAMP   = 3'b110,
    S_HOLD   = 3'b111,
    S_SAFE   = 3'b101,
    S_FAIL   = 3'b100
  } state_e;

  function automatic logic mode_valid(input logic [MODE_W-1:0] m);
    mode_valid = (m >= 3'h1) && (m <= 3'h6);
  endfunction

  function automatic logic mode_has_stop(input logic [MODE_W-1:0] m);
    mode_has_stop = (m == 3'h1) || (m == 3'h2) || (m == 3'h5);
  endfunction

  function automatic logic mode_fixed_part(input logic [MODE_W-1:0] m);
    mode_fixed_part = (m == 3'h2) || (m == 3'h4);
  endfunction

  function automatic logic mode_ramp_part(input logic [MODE_W-1:0] m);
    mode_ramp_part = (m == 3'h5) || (m == 3'h6);
  endfunction

endpackage

// ---- tick_divider.sv ----
// free-running divider giving a one-cycle enable every DIV clocks
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int DIV = 4
) (
  input  wire logic clk,
  input  wire logic reset,
  output logic      tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] count;
  wire           at_last = (count == LAST);

  always_ff @(posedge clk) begin
    if (reset) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      tick  <= at_last;
      count <= at_last ? '0 : count + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- safe_pair_check.sv ----
// two-channel safe input: level channel plus pulsed channel against reference
`timescale 1ns/1ps
`default_nettype none
module safe_pair_check
  import door_drive_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic level_in,
  input  wire logic pulse_in,
  input  wire logic ref_pulse,
  input  wire logic sample,
  output logic      level_ok,
  output logic      pulse_ok,
  output logic      active
);
  logic [1:0] match_cnt;

  // a stuck or shorted pulse line fails one of the next two samples
  wire matched = (pulse_in == ref_pulse);

  always_ff @(posedge clk) begin
    if (reset) begin
      level_ok  <= 1'b0;
      match_cnt <= 2'h0;
    end else begin
      level_ok <= level_in;
      if (sample) begin
        if (!matched) begin
          match_cnt <= 2'h0;
        end else if (match_cnt != MATCH_NEED) begin
          match_cnt <= match_cnt + 2'h1;
        end
      end
    end
  end

  // both phases must have matched before the channel counts
  assign pulse_ok = (match_cnt == MATCH_NEED);
  assign active   = level_ok & pulse_ok;
endmodule
`default_nettype wire

// ---- door_drive_io_safety_modes.sv ----
// command input, safety mode and motion sequencing for the door drive
`timescale 1ns/1ps
`default_nettype none
module door_drive_io_safety_modes
  import door_drive_pkg::*;
#(
  parameter int PULSE_HALF = PULSE_HALF_CYC,
  parameter int FLASH_HALF = FLASH_HALF_CYC,
  parameter int SKEW_LIM   = SKEW_CYC,
  parameter int CLEAR_LIM  = CLEAR_CYC
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              open_cmd,
  input  wire logic              close_cmd,
  input  wire logic              stop_n,
  input  wire logic              partial_cmd,
  input  wire logic              torque_off_level_chan_n,
  input  wire logic              torque_off_pulse_chan_n,
  input  wire logic              normal_mode_level_chan_n,
  input  wire logic              normal_mode_pulse_chan_n,
  input  wire logic [DATA_W-1:0] position,
  input  wire logic              at_standstill,
  input  wire logic              obstacle,
  input  wire logic              safe_func_trip,
  input  wire logic              internal_error,
  output logic                   test_pulse,
  output logic                   amp_enable,
  output logic                   drive_open,
  output logic                   drive_close,
  output logic                   ramp_down,
  output logic                   hold_torque,
  output logic                   ref_speed,
  output logic                   safe_limits,
  output logic      [DATA_W-1:0] target_pos,
  output logic      [DATA_W-1:0] holding_force,
  output logic                   closed_status,
  output logic                   open_status,
  output logic                   option_out,
  output logic                   safety_out,
  output logic                   safety_indicator,
  output logic                   alarm_out
);

  // ------------------------------------------------------------
  // registers and state
  // ------------------------------------------------------------
  logic [MODE_W-1:0]  operating_mode_code;
  logic [OPT_W-1:0]   opt_func;
  logic [DATA_W-1:0]  open_pos;
  logic [DATA_W-1:0]  part_pos;
  logic [DATA_W-1:0]  closing_force_params;
  logic [DATA_W-1:0]  closed_pos;
  state_e             state;
  state_e             next_state;
  logic [DATA_W-1:0]  next_target;
  logic               open_dir;
  logic               next_open_dir;
  logic               ref_done;
  logic               wire_break;
  logic               torque_ok_d;
  logic               partial_d;
  logic               flash;
  logic [TIMER_W-1:0] skew_cnt;
  logic [TIMER_W-1:0] clear_cnt;

  // ------------------------------------------------------------
  // test pulse source and safe input checks
  // ------------------------------------------------------------
  logic pulse_tick;
  logic flash_tick;
  logic tq_level_ok;
  logic tq_pulse_ok;
  logic torque_ok;
  logic nm_level_ok;
  logic nm_pulse_ok;
  logic normal_ok;

  tick_divider #(
    .DIV (PULSE_HALF)
  ) u_pulse_div (
    .clk   (clk),
    .reset (reset),
    .tick  (pulse_tick)
  );

  tick_divider #(
    .DIV (FLASH_HALF)
  ) u_flash_div (
    .clk   (clk),
    .reset (reset),
    .tick  (flash_tick)
  );

  safe_pair_check u_torque_chk (
    .clk       (clk),
    .reset     (reset),
    .level_in  (torque_off_level_chan_n),
    .pulse_in  (torque_off_pulse_chan_n),
    .ref_pulse (test_pulse),
    .sample    (pulse_tick),
    .level_ok  (tq_level_ok),
    .pulse_ok  (tq_pulse_ok),
    .active    (torque_ok)
  );

  safe_pair_check u_normal_chk (
    .clk       (clk),
    .reset     (reset),
    .level_in  (normal_mode_level_chan_n),
    .pulse_in  (normal_mode_pulse_chan_n),
    .ref_pulse (test_pulse),
    .sample    (pulse_tick),
    .level_ok  (nm_level_ok),
    .pulse_ok  (nm_pulse_ok),
    .active    (normal_ok)
  );

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire cmd_open  = open_cmd & ~close_cmd;
  wire cmd_close = close_cmd & ~open_cmd;
  wire any_cmd   = open_cmd | close_cmd;
  // low stop reads as a stop hit in modes 1, 2 and 5, so a cut wire also stops there
  wire stop_hit  = mode_has_stop(operating_mode_code) & ~stop_n;
  wire dir_cmd   = open_dir ? cmd_open : cmd_close;
  wire part_rise = partial_cmd & ~partial_d;
  wire ramp_part = open_dir & mode_ramp_part(operating_mode_code) & part_rise;
  wire reached   = open_dir ? (position >= target_pos) : (position <= target_pos);
  wire torque_lost = torque_ok_d & ~torque_ok;
  wire skew_on   = tq_level_ok ^ tq_pulse_ok;
  wire skew_hit  = skew_on & (skew_cnt == TIMER_W'(SKEW_LIM - 1));
  wire trip      = torque_lost | safe_func_trip | skew_hit;
  wire chans_off = ~tq_level_ok & ~tq_pulse_ok;
  wire clear_ok  = ~any_cmd & chans_off;
  wire clear_hit = clear_ok & (clear_cnt == TIMER_W'(CLEAR_LIM - 1));
  wire settled   = ref_done ? 1'b1 : 1'b0;
  wire use_part  = mode_fixed_part(operating_mode_code) & partial_cmd;
  wire [DATA_W-1:0] open_tgt = use_part ? part_pos : open_pos;
  wire active_st = (next_state != S_SAFE) && (next_state != S_FAIL);

  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------
  always_comb begin
    next_state    = state;
    next_target   = target_pos;
    next_open_dir = open_dir;
    case (state)
      S_NOREF: begin
        if (cmd_close && torque_ok) begin
          next_state    = S_REFRUN;
          next_open_dir = 1'b0;
        end
      end
      S_REFRUN: begin
        if (stop_hit) begin
          next_state = S_NOREF;
        end else if (!cmd_close) begin
          next_state = S_RAMP;
        end else if (obstacle) begin
          next_state  = S_HOLD;
          next_target = position;
        end
      end
      S_IDLE: begin
        if (torque_ok && cmd_close) begin
          next_state    = S_MOVE;
          next_open_dir = 1'b0;
          next_target   = closed_pos;
        end else if (torque_ok && cmd_open) begin
          next_state    = S_MOVE;
          next_open_dir = 1'b1;
          next_target   = open_tgt;
        end
      end
      S_MOVE: begin
        if (stop_hit) begin
          next_state = S_IDLE;
        end else if (!dir_cmd || ramp_part) begin
          next_state = S_RAMP;
        end else if (reached) begin
          next_state = S_HOLD;
        end
      end
      S_RAMP: begin
        if (at_standstill || stop_hit) begin
          next_state = settled ? S_IDLE : S_NOREF;
        end
      end
      S_HOLD: begin
        if (!dir_cmd) begin
          next_state = S_IDLE;
        end
      end
      S_SAFE: begin
        // movement commands only hold off the clearing sequence here
        if (clear_hit) begin
          next_state = settled ? S_IDLE : S_NOREF;
        end
      end
      S_FAIL: begin
        next_state = S_FAIL;
      end
      default: begin
        next_state = S_NOREF;
      end
    endcase
    if (internal_error) begin
      next_state = S_FAIL;
    end else if (trip && state != S_SAFE && state != S_FAIL) begin
      next_state = S_SAFE;
    end
  end

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  wire [DATA_W-1:0] status_word = DATA_W'({
    3'(state), wire_break, torque_ok, normal_ok, ref_done});
  wire [DATA_W-1:0] read_mux =
    (reg_addr == ADR_MODE)       ? DATA_W'(operating_mode_code) :
    (reg_addr == ADR_OPT_FUNC)   ? DATA_W'(opt_func) :
    (reg_addr == ADR_OPEN_POS)   ? open_pos :
    (reg_addr == ADR_PART_POS)   ? part_pos :
    (reg_addr == ADR_FORCE)      ? closing_force_params :
    (reg_addr == ADR_STATUS)     ? status_word :
    (reg_addr == ADR_CLOSED_POS) ? closed_pos : '0;
  wire mode_wr = reg_wr && (reg_addr == ADR_MODE);
  wire mode_in = mode_valid(reg_wdata[MODE_W-1:0]) && (reg_wdata[DATA_W-1:MODE_W] == '0);

  always_ff @(posedge clk) begin
    if (reset) begin
      operating_mode_code  <= MODE_RST;
      opt_func             <= OPT_RST;
      open_pos             <= OPEN_POS_RST;
      part_pos             <= PART_POS_RST;
      closing_force_params <= FORCE_RST;
      reg_rdata            <= '0;
    end else begin
      if (mode_wr && mode_in) begin
        operating_mode_code <= reg_wdata[MODE_W-1:0];
      end
      if (reg_wr && reg_addr == ADR_OPT_FUNC) begin
        opt_func <= reg_wdata[OPT_W-1:0];
      end
      if (reg_wr && reg_addr == ADR_OPEN_POS) begin
        open_pos <= reg_wdata;
      end
      if (reg_wr && reg_addr == ADR_PART_POS) begin
        part_pos <= reg_wdata;
      end
      if (reg_wr && reg_addr == ADR_FORCE) begin
        closing_force_params <= reg_wdata;
      end
      reg_rdata <= reg_rd ? read_mux : '0;
    end
  end

  // ------------------------------------------------------------
  // state, timers and flags
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state       <= S_NOREF;
      open_dir    <= 1'b0;
      ref_done    <= 1'b0;
      closed_pos  <= '0;
      wire_break  <= 1'b0;
      torque_ok_d <= 1'b0;
      partial_d   <= 1'b0;
      skew_cnt    <= '0;
      clear_cnt   <= '0;
    end else begin
      state       <= next_state;
      open_dir    <= next_open_dir;
      torque_ok_d <= torque_ok;
      partial_d   <= partial_cmd;
      if (state == S_REFRUN && next_state == S_HOLD) begin
        ref_done   <= 1'b1;
        closed_pos <= position;
      end
      // fault sticks until the clearing sequence; a new one wins
      if (skew_hit) begin
        wire_break <= 1'b1;
      end else if (clear_hit) begin
        wire_break <= 1'b0;
      end
      skew_cnt  <= skew_on && !skew_hit ? skew_cnt + 1'b1 : '0;
      clear_cnt <= (state == S_SAFE) && clear_ok && !clear_hit
                   ? clear_cnt + 1'b1 : '0;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      test_pulse       <= 1'b0;
      flash            <= 1'b0;
      amp_enable       <= 1'b0;
      drive_open       <= 1'b0;
      drive_close      <= 1'b0;
      ramp_down        <= 1'b0;
      hold_torque      <= 1'b0;
      ref_speed        <= 1'b0;
      safe_limits      <= 1'b1;
      target_pos       <= '0;
      holding_force    <= '0;
      closed_status    <= 1'b0;
      open_status      <= 1'b0;
      option_out       <= 1'b0;
      safety_out       <= 1'b0;
      safety_indicator <= 1'b0;
      alarm_out        <= 1'b0;
    end else begin
      if (pulse_tick) begin
        test_pulse <= ~test_pulse;
      end
      if (flash_tick) begin
        flash <= ~flash;
      end
      amp_enable    <= torque_ok & active_st;
      drive_open    <= (next_state == S_MOVE) & next_open_dir;
      drive_close   <= ((next_state == S_MOVE) & ~next_open_dir)
                       | (next_state == S_REFRUN);
      ramp_down     <= (next_state == S_RAMP);
      hold_torque   <= (next_state == S_HOLD);
      ref_speed     <= (next_state == S_REFRUN);
      safe_limits   <= ~normal_ok | ~torque_ok;
      target_pos    <= next_target;
      holding_force <= (next_state == S_HOLD) && !next_open_dir
                       ? closing_force_params : '0;
      closed_status <= (next_state == S_HOLD) & ~next_open_dir;
      open_status   <= (next_state == S_HOLD) & next_open_dir
                       & (next_target == open_pos);
      option_out    <= (opt_func == OPT_FUNC_REF) & ref_done;
      alarm_out     <= (next_state == S_FAIL);
      if (next_state == S_SAFE) begin
        safety_out       <= flash;
        safety_indicator <= flash;
      end else begin
        safety_out       <= ~normal_ok & active_st;
        safety_indicator <= ~normal_ok & active_st;
      end
    end
  end

endmodule
`default_nettype wire

// ---- door_drive_chk.sv ----
// assertion checker for the door drive command and safety block
`timescale 1ns/1ps
`default_nettype none
module door_drive_chk
  import door_drive_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              open_cmd,
  input wire logic              close_cmd,
  input wire logic              torque_off_level_chan_n,
  input wire logic              normal_mode_level_chan_n,
  input wire logic [DATA_W-1:0] position,
  input wire logic              safe_func_trip,
  input wire logic              internal_error,
  input wire logic              amp_enable,
  input wire logic              drive_open,
  input wire logic              drive_close,
  input wire logic              hold_torque,
  input wire logic              ref_speed,
  input wire logic              safe_limits,
  input wire logic [DATA_W-1:0] target_pos,
  input wire logic              closed_status,
  input wire logic              open_status,
  input wire logic              option_out,
  input wire logic              alarm_out
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (reset);
  // ------------------------------------------------------------
  // safety and motion relations
  // ------------------------------------------------------------
  amp_loss_a: assert property ($fell(torque_off_level_chan_n) |-> ##[1:3] !amp_enable)
    else $error("amplifier on after torque-off loss");
  trip_safe_a: assert property (safe_func_trip |-> ##[1:2] !amp_enable)
    else $error("amplifier on after safe trip");
  fail_entry_a: assert property (internal_error |-> ##[1:2] (alarm_out && !amp_enable))
    else $error("fail mode not entered");
  fail_keep_a: assert property (alarm_out |=> alarm_out && !drive_open && !drive_close)
    else $error("fail mode left or motion in fail");
  both_cmd_a: assert property (open_cmd && close_cmd |=> !drive_open && !drive_close)
    else $error("motion on conflicting commands");
  closed_hold_a: assert property ($rose(closed_status) |-> hold_torque)
    else $error("closed without holding");
  open_hold_a: assert property ($rose(open_status) |-> hold_torque && position >= target_pos)
    else $error("open flagged early or without holding");
  ref_dir_a: assert property (ref_speed |-> drive_close && !drive_open)
    else $error("reference speed outside closing run");
  normal_lim_a: assert property (!normal_mode_level_chan_n |-> ##[1:3] safe_limits)
    else $error("limits off without mode channel");
  cover property (closed_status && option_out);
  cover property (open_status && hold_torque);
  cover property (alarm_out);
endmodule
bind door_drive_io_safety_modes door_drive_chk door_drive_chk_i (
  .clk, .reset, .open_cmd, .close_cmd, .torque_off_level_chan_n, .normal_mode_level_chan_n,
  .position, .safe_func_trip, .internal_error, .amp_enable, .drive_open, .drive_close,
  .hold_torque, .ref_speed, .safe_limits, .target_pos, .closed_status, .open_status,
  .option_out, .alarm_out);
`default_nettype wire

// ---- plc_model.sv ----
// machine controller model feeding the two safe input pairs
`timescale 1ns/1ps
`default_nettype none
module plc_model (
  input  wire logic test_pulse,
  input  wire logic t_lvl,
  input  wire logic t_pls,
  input  wire logic m_lvl,
  input  wire logic m_pls,
  output logic      torque_off_level_chan_n,
  output logic      torque_off_pulse_chan_n,
  output logic      normal_mode_level_chan_n,
  output logic      normal_mode_pulse_chan_n
);
  // ------------------------------------------------------------
  // contacts
  // ------------------------------------------------------------
  // an open contact reads low through the input pull-down, never a stale pulse
  assign torque_off_level_chan_n  = t_lvl;
  assign torque_off_pulse_chan_n  = t_pls & test_pulse;
  assign normal_mode_level_chan_n = m_lvl;
  assign normal_mode_pulse_chan_n = m_pls & test_pulse;
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the door drive command and safety block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import door_drive_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic              clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, position = 16'h0010;
  logic              open_cmd = 1'b0, close_cmd = 1'b0, stop_n = 1'b1, partial_cmd = 1'b0;
  logic              at_standstill = 1'b1, obstacle = 1'b0;
  logic              safe_func_trip = 1'b0, internal_error = 1'b0;
  logic              t_lvl = 1'b0, t_pls = 1'b0, m_lvl = 1'b0, m_pls = 1'b0;
  logic              torque_off_level_chan_n, torque_off_pulse_chan_n;
  logic              normal_mode_level_chan_n, normal_mode_pulse_chan_n;
  logic [DATA_W-1:0] reg_rdata, target_pos, holding_force;
  logic              test_pulse, amp_enable, drive_open, drive_close, ramp_down, hold_torque;
  logic              ref_speed, safe_limits, closed_status, open_status, option_out;
  logic              safety_out, safety_indicator, alarm_out;
  int                errors = 0, total_checks = 0;

  always #12.5 clk = ~clk;

  // short counts keep the safety timers within a quick run
  door_drive_io_safety_modes #(.PULSE_HALF(4), .FLASH_HALF(8), .SKEW_LIM(50), .CLEAR_LIM(60))
    door_drive_io_safety_modes_i (.*);
  plc_model plc_model_i (.test_pulse, .t_lvl, .t_pls, .m_lvl, .m_pls,
    .torque_off_level_chan_n, .torque_off_pulse_chan_n,
    .normal_mode_level_chan_n, .normal_mode_pulse_chan_n);

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk($sformatf("register %0h", a), reg_rdata, e);
  endtask
  task automatic apply(input int o, c, p, s, input logic [DATA_W-1:0] pos, input int n);
    @(posedge clk);
    open_cmd <= o[0];
    close_cmd <= c[0];
    partial_cmd <= p[0];
    stop_n <= s[0];
    position <= pos;
    settle(n);
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    logic [DATA_W-1:0] dflt [5];
    logic [DATA_W-1:0] prev;
    logic [2:0]        last;
    logic [2:0]        seen3;
    int                flips [3];
    dflt = '{16'h0001, 16'h0001, 16'h4000, 16'h2000, 16'h0100};
    prev = 16'h0001;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++) rd(ADDR_W'(i), dflt[i]);
    rd(ADR_STATUS, 16'h0000);
    rd(4'hF, 16'h0000);
    for (int m = 0; m < 8; m++) begin
      wr(ADR_MODE, DATA_W'(m));
      if (m >= 1 && m <= 6) prev = DATA_W'(m);
      rd(ADR_MODE, prev);
    end
    wr(ADR_MODE, 16'h0001);
    @(posedge clk);
    {t_lvl, t_pls} <= 2'b11;
    settle(16);
    rd(ADR_STATUS, 16'h0004);
    apply(0, 1, 0, 1, 16'h0010, 1);
    chk("ref run", {drive_close, ref_speed}, 2'b11);
    @(posedge clk);
    obstacle <= 1'b1;
    settle(1);
    chk("closed hold", {hold_torque, closed_status, holding_force}, {2'b11, 16'h0100});
    settle(1);
    chk("option", option_out, 1'b1);
    @(posedge clk);
    obstacle <= 1'b0;
    apply(0, 0, 0, 1, 16'h0010, 1);
    chk("torque free", hold_torque, 1'b0);
    rd(ADR_CLOSED_POS, 16'h0010);
    wr(ADR_OPT_FUNC, 16'h0002);
    settle(1);
    chk("option off", option_out, 1'b0);
    wr(ADR_OPT_FUNC, 16'h0001);
    apply(1, 0, 0, 1, 16'h0010, 1);
    chk("open run", {drive_open, target_pos}, {1'b1, 16'h4000});
    apply(1, 0, 0, 0, 16'h0010, 1);
    chk("stop halts", drive_open, 1'b0);
    apply(0, 0, 0, 1, 16'h0010, 1);
    wr(ADR_MODE, 16'h0003);
    apply(1, 0, 0, 0, 16'h0010, 2);
    chk("stop ignored", drive_open, 1'b1);
    apply(1, 0, 0, 0, 16'h4000, 1);
    chk("open hold", {open_status, hold_torque}, 2'b11);
    apply(0, 0, 0, 1, 16'h0100, 1);
    wr(ADR_MODE, 16'h0002);
    apply(1, 0, 1, 1, 16'h0100, 1);
    chk("partial target", target_pos, 16'h2000);
    apply(1, 0, 1, 1, 16'h2000, 1);
    chk("partial hold", {open_status, hold_torque}, 2'b01);
    apply(0, 0, 0, 1, 16'h0100, 1);
    wr(ADR_MODE, 16'h0005);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      at_standstill <= 1'b0;
      apply(1, 0, 0, 1, 16'h0100, 1);
      apply(k == 0, 0, k == 0, 1, 16'h0100, 1);
      chk("ramp", {ramp_down, drive_open}, 2'b10);
      @(posedge clk);
      at_standstill <= 1'b1;
      apply(0, 0, 0, 1, 16'h0100, 1);
      chk("stopped", {ramp_down, hold_torque}, 2'b00);
    end
    apply(1, 0, 0, 1, 16'h0100, 1);
    apply(1, 1, 0, 1, 16'h0100, 1);
    chk("both cmds", {drive_open, drive_close}, 2'b00);
    apply(0, 0, 0, 1, 16'h0100, 1);
    @(posedge clk);
    {m_lvl, m_pls} <= 2'b11;
    settle(16);
    chk("normal", {safe_limits, safety_out, safety_indicator}, 3'b000);
    @(posedge clk);
    m_lvl <= 1'b0;
    settle(10);
    chk("safety mode", {safe_limits, safety_out, safety_indicator}, 3'b111);
    @(posedge clk);
    safe_func_trip <= 1'b1;
    @(posedge clk);
    safe_func_trip <= 1'b0;
    settle(1);
    chk("trip", amp_enable, 1'b0);
    rd(ADR_STATUS, 16'h0055);
    flips = '{0, 0, 0};
    last = {test_pulse, safety_indicator, safety_out};
    repeat (16) begin
      @(negedge clk);
      seen3 = {test_pulse, safety_indicator, safety_out};
      for (int b = 0; b < 3; b++) begin
        if (seen3[b] !== last[b]) flips[b]++;
      end
      last = seen3;
    end
    chk("flash", flips[0], 2);
    chk("indicator", flips[1], 2);
    chk("test pulse", flips[2], 4);
    apply(1, 0, 0, 1, 16'h0100, 2);
    chk("safe ignores", {drive_open, amp_enable}, 2'b00);
    apply(0, 0, 0, 1, 16'h0100, 0);
    @(posedge clk);
    {t_lvl, t_pls} <= 2'b00;
    settle(80);
    rd(ADR_STATUS, 16'h0031);
    @(posedge clk);
    {t_lvl, t_pls} <= 2'b11;
    settle(16);
    @(posedge clk);
    t_lvl <= 1'b0;
    settle(60);
    rd(ADR_STATUS, 16'h0059);
    @(posedge clk);
    internal_error <= 1'b1;
    @(posedge clk);
    internal_error <= 1'b0;
    settle(4);
    chk("fail", {alarm_out, amp_enable}, 2'b10);
    rd(ADR_STATUS, 16'h0049);
    // only a reset leaves fail mode
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    settle(1);
    chk("fail cleared", {alarm_out, amp_enable, safe_limits}, 3'b001);
    rd(ADR_STATUS, 16'h0000);
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
